// ### phy_cable_diag_control_status.v
// Port PHY special control/status slice: cable diagnostic control and
// results, link pass override, remote loopback for ports 1 and 2, and
// an interrupt on diagnostic completion and link change.
// Assumes a single-cycle register master on clk_in and PMA symbol
// streams that are already on clk_in; the line link level is async.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "phy_diag_regs.vh"

// Overview of operation
// - Bit 7 flags short nearer than ten metres.
// - Bits 6:5 give outcome, reset to normal.
// - Writing bit 4 starts test, self-clears.
// - Bit 4 zero means results are valid.
// - Bit 1 loops receive pair to transmit.
// - Port 2 loop at offset 0x2a.
// - Port 1 loop through bit 1 of 0x1a.
// - Bit 0 shows fault count bit eight.
// - Next register holds count low byte.
// - Port 3 offsets stay reserved, unimplemented.
module phy_cable_diag_control_status #(
   parameter [`TMO_W-1:0] DIAG_TIMEOUT_CYCLES = `DIAG_TIMEOUT_US * `CLK_MHZ
) (
   input wire clk_in,
   input wire reset_n_in,
   input wire ce_in,
   input wire [`ADDR_W-1:0] addr_in,
   input wire [`DATA_W-1:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output wire [`DATA_W-1:0] rdata_out,
   output wire irq_out,
   input wire line_link_in,
   output wire link_status_out,
   output wire diag_req_out,
   input wire diag_ack_in,
   input wire [1:0] diag_result_in,
   input wire [`COUNT_W-1:0] diag_count_in,
   input wire [`SYM_W-1:0] port1_receive_pair_sym_in,
   input wire [`SYM_W-1:0] port1_mac_tx_sym_in,
   output wire [`SYM_W-1:0] port1_transmit_pair_sym_out,
   input wire [`SYM_W-1:0] port2_receive_pair_sym_in,
   input wire [`SYM_W-1:0] port2_mac_tx_sym_in,
   output wire [`SYM_W-1:0] port2_transmit_pair_sym_out
);

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------

   function hit;
      input [`ADDR_W-1:0] addr;
      input [`ADDR_W-1:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   wire wr_p1;
   wire wr_p2;
   wire wr_int_status;
   wire wr_int_mask;

   // A strobe that meets ce_in low is lost; the master must not issue one
   // while the block is frozen.
   assign wr_p1 = wr_in && hit(addr_in, `OFS_P1_SPECIAL);
   assign wr_p2 = wr_in && hit(addr_in, `OFS_P2_SPECIAL);
   assign wr_int_status = wr_in && hit(addr_in, `OFS_INT_STATUS);
   assign wr_int_mask = wr_in && hit(addr_in, `OFS_INT_MASK);

   // ----------------------------------------------------------------------
   // Read strobe decode
   // ----------------------------------------------------------------------

   wire rd_p1;
   wire rd_p2;
   wire rd_dist;
   wire rd_int_status;
   wire rd_int_mask;
   wire rd_p3_hole;

   assign rd_p1 = rd_in && hit(addr_in, `OFS_P1_SPECIAL);
   assign rd_p2 = rd_in && hit(addr_in, `OFS_P2_SPECIAL);
   assign rd_dist = rd_in && hit(addr_in, `OFS_DIST_LOW);
   assign rd_int_status = rd_in && hit(addr_in, `OFS_INT_STATUS);
   assign rd_int_mask = rd_in && hit(addr_in, `OFS_INT_MASK);
   // port 3 holes
   // Port 3 has no PHY behind it; its two offsets are named here only so
   // that no later decode can quietly claim them.
   assign rd_p3_hole = rd_in && (hit(addr_in, `OFS_P3_SPECIAL) || hit(addr_in, `OFS_P3_DIST));

   // ----------------------------------------------------------------------
   // Control bits written by software
   // ----------------------------------------------------------------------

   reg link_ovr_ff;
   reg p2_loop_ff;
   reg p1_loop_ff;
   reg nxt_link_ovr;
   reg nxt_p2_loop;
   reg nxt_p1_loop;

   // Only port 2 carries the link override; the port 1 register keeps just
   // its loopback enable.
   always @* begin
      nxt_link_ovr = link_ovr_ff;
      nxt_p2_loop = p2_loop_ff;
      nxt_p1_loop = p1_loop_ff;
      if (wr_p2) begin
         nxt_link_ovr = wdata_in[`BIT_LINK_OVR];
         nxt_p2_loop = wdata_in[`BIT_REMOTE_LB];
      end
      if (wr_p1) begin
         nxt_p1_loop = wdata_in[`BIT_REMOTE_LB];
      end
   end

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         link_ovr_ff <= 1'b0;
         p2_loop_ff <= 1'b0;
         p1_loop_ff <= 1'b0;
      end else if (ce_in) begin
         link_ovr_ff <= nxt_link_ovr;
         p2_loop_ff <= nxt_p2_loop;
         p1_loop_ff <= nxt_p1_loop;
      end
   end

   // ----------------------------------------------------------------------
   // Cable diagnostic engine
   // ----------------------------------------------------------------------

   wire diag_start;
   wire diag_busy;
   wire diag_done;
   wire [1:0] diag_result;
   wire [`COUNT_W-1:0] diag_count;
   wire near_short;

   // start on written one
   // A one written while a test runs is absorbed; the test cannot be
   // aborted or restarted from software.
   assign diag_start = wr_p2 && wdata_in[`BIT_DIAG_START] && !diag_busy;

   // The engine keeps its last results until the next test completes, so
   // software may read them at leisure once bit 4 has fallen. A front end
   // that never answers is cut off after DIAG_TIMEOUT_CYCLES and reported
   // as a failed test.
   cable_diag_engine #(
      .TIMEOUT_CYCLES(DIAG_TIMEOUT_CYCLES)
   ) u_diag (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .ce_in(ce_in),
      .start_in(diag_start),
      .ack_in(diag_ack_in),
      .fe_result_in(diag_result_in),
      .fe_count_in(diag_count_in),
      .busy_out(diag_busy),
      .done_out(diag_done),
      .req_out(diag_req_out),
      .result_ff(diag_result),
      .count_ff(diag_count),
      .near_short_ff(near_short)
   );

   // ----------------------------------------------------------------------
   // Line link level and override
   // ----------------------------------------------------------------------

   // The line level comes from the analog signal detector, so it is
   // brought onto clk_in before anything looks at it.
   reg link_meta_ff;
   reg link_sync_ff;
   reg link_out_ff;
   reg nxt_link_out;

   // The override only touches the reported level; the detector keeps
   // running, so clearing it brings back the true line state on the next edge.
   always @* begin
      nxt_link_out = link_ovr_ff | link_sync_ff;
   end

   // The event is taken from the next value, so it lands on the same edge
   // as the visible change on link_status_out.
   wire link_change;
   assign link_change = (nxt_link_out != link_out_ff);

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         link_meta_ff <= 1'b0;
         link_sync_ff <= 1'b0;
         link_out_ff <= 1'b0;
      end else if (ce_in) begin
         link_meta_ff <= line_link_in;
         link_sync_ff <= link_meta_ff;
         link_out_ff <= nxt_link_out;
      end
   end

   assign link_status_out = link_out_ff;

   // ----------------------------------------------------------------------
   // Remote loopback symbol paths
   // ----------------------------------------------------------------------

   reg [`SYM_W-1:0] p1_tx_ff;
   reg [`SYM_W-1:0] p2_tx_ff;
   reg [`SYM_W-1:0] nxt_p1_tx;
   reg [`SYM_W-1:0] nxt_p2_tx;

   // Turning around at the PMA keeps the MAC and switch fabric out of the
   // loop, so a far tester sees its own symbols one cycle later.
   always @* begin
      // Each port's select comes only from its own register.
      // turn receive around
      nxt_p1_tx = p1_loop_ff ? port1_receive_pair_sym_in : port1_mac_tx_sym_in;
      nxt_p2_tx = p2_loop_ff ? port2_receive_pair_sym_in : port2_mac_tx_sym_in;
   end

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         p1_tx_ff <= `RST_SYM;
         p2_tx_ff <= `RST_SYM;
      end else if (ce_in) begin
         p1_tx_ff <= nxt_p1_tx;
         p2_tx_ff <= nxt_p2_tx;
      end
   end

   assign port1_transmit_pair_sym_out = p1_tx_ff;
   assign port2_transmit_pair_sym_out = p2_tx_ff;

   // ----------------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------------

   reg [`INT_W-1:0] int_status_ff;
   reg [`INT_W-1:0] int_mask_ff;
   reg [`INT_W-1:0] nxt_int_status;
   reg [`INT_W-1:0] nxt_int_mask;
   reg [`INT_W-1:0] int_events;

   always @* begin
      int_events = `RST_INT;
      int_events[`INT_DIAG_DONE] = diag_done;
      int_events[`INT_LINK_CHG] = link_change;
      nxt_int_status = int_status_ff;
      if (wr_int_status) begin
         nxt_int_status = int_status_ff & ~wdata_in[`INT_W-1:0];
      end
      // An event in the clearing cycle must survive the write.
      nxt_int_status = nxt_int_status | int_events;
      nxt_int_mask = int_mask_ff;
      if (wr_int_mask) begin
         nxt_int_mask = wdata_in[`INT_W-1:0];
      end
   end

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         int_status_ff <= `RST_INT;
         int_mask_ff <= `RST_INT;
      end else if (ce_in) begin
         int_status_ff <= nxt_int_status;
         int_mask_ff <= nxt_int_mask;
      end
   end

   // Masking hides an event from irq_out but never stops it being recorded.
   assign irq_out = |(int_status_ff & int_mask_ff);

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------

   reg [`DATA_W-1:0] rdata_ff;
   reg [`DATA_W-1:0] nxt_rdata;
   reg [`DATA_W-1:0] p2_view;
   reg [`DATA_W-1:0] p1_view;
   reg [`DATA_W-1:0] int_view;
   reg [`DATA_W-1:0] mask_view;

   always @* begin
      p2_view = `RST_BYTE;
      p2_view[`BIT_NEAR_SHORT] = near_short;
      p2_view[`BIT_RESULT_HI:`BIT_RESULT_LO] = diag_result;
      p2_view[`BIT_DIAG_START] = diag_busy;
      p2_view[`BIT_LINK_OVR] = link_ovr_ff;
      p2_view[`BIT_RSVD] = 1'b0;
      p2_view[`BIT_REMOTE_LB] = p2_loop_ff;
      p2_view[`BIT_COUNT_MSB] = diag_count[`COUNT_W-1];

      p1_view = `RST_BYTE;
      p1_view[`BIT_REMOTE_LB] = p1_loop_ff;

      int_view = `RST_BYTE;
      int_view[`INT_W-1:0] = int_status_ff;
      mask_view = `RST_BYTE;
      mask_view[`INT_W-1:0] = int_mask_ff;

      nxt_rdata = `RST_BYTE;
      if (rd_p2) begin
         nxt_rdata = p2_view;
      end else if (rd_dist) begin
         nxt_rdata = diag_count[`COUNT_LOW_HI:0];
      end else if (rd_p1) begin
         nxt_rdata = p1_view;
      end else if (rd_int_status) begin
         nxt_rdata = int_view;
      end else if (rd_int_mask) begin
         nxt_rdata = mask_view;
      end else if (rd_p3_hole) begin
         nxt_rdata = `RST_BYTE;
      end else begin
         // Other holes, and cycles with no read, return zero.
         nxt_rdata = `RST_BYTE;
      end
   end

   // Read data stand only in the cycle after the strobe, so a stale
   // value can never be taken for a fresh read.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_ff <= `RST_BYTE;
      end else if (ce_in) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata_out = rdata_ff;

endmodule

// ### phy_diag_regs.vh
// Constants for the port PHY special control/status slice and its
// cable diagnostic engine.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef PHY_DIAG_REGS_VH
`define PHY_DIAG_REGS_VH

// ----------------------------------------------------------------------
// Bus widths
// ----------------------------------------------------------------------
`define ADDR_W 8
`define DATA_W 8
`define SYM_W 5
`define COUNT_W 9
`define TMO_W 24
`define INT_W 2

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_P1_SPECIAL 8'h1a
`define OFS_P2_SPECIAL 8'h2a
`define OFS_DIST_LOW 8'h2b
`define OFS_P3_SPECIAL 8'h3a
`define OFS_P3_DIST 8'h3b
`define OFS_INT_STATUS 8'h80
`define OFS_INT_MASK 8'h81

// ----------------------------------------------------------------------
// Field positions of the special control/status register
// ----------------------------------------------------------------------
`define BIT_NEAR_SHORT 7
`define BIT_RESULT_HI 6
`define BIT_RESULT_LO 5
`define BIT_DIAG_START 4
`define BIT_LINK_OVR 3
`define BIT_RSVD 2
`define BIT_REMOTE_LB 1
`define BIT_COUNT_MSB 0
`define COUNT_LOW_HI 7

// ----------------------------------------------------------------------
// Interrupt status/mask bit positions
// ----------------------------------------------------------------------
`define INT_DIAG_DONE 0
`define INT_LINK_CHG 1

// ----------------------------------------------------------------------
// Diagnostic outcome codes
// ----------------------------------------------------------------------
`define RES_NORMAL 2'h0
`define RES_OPEN 2'h1
`define RES_SHORT 2'h2
`define RES_FAIL 2'h3

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_COUNT 9'h000
`define RST_SYM 5'h00
`define RST_INT 2'h0
`define RST_TMO 24'h000000
`define CLK_MHZ 24'h000019
`define DIAG_TIMEOUT_US 24'h0003e8
`define COUNT_STEP_DM 4
`define NEAR_SHORT_DM 100

`endif

// ### cable_diag_engine.v
// Cable diagnostic sequencer: requests a measurement from the analog
// front end and captures outcome, fault count and near short flag.
// Assumes the front end answers on clk_in with a one-cycle acknowledge.
`timescale 1ns/1ps
`include "phy_diag_regs.vh"

module cable_diag_engine #(
   parameter [`TMO_W-1:0] TIMEOUT_CYCLES = `DIAG_TIMEOUT_US * `CLK_MHZ
) (
   input wire clk_in,
   input wire reset_n_in,
   input wire ce_in,
   input wire start_in,
   input wire ack_in,
   input wire [1:0] fe_result_in,
   input wire [`COUNT_W-1:0] fe_count_in,
   output wire busy_out,
   output reg done_out,
   output wire req_out,
   output reg [1:0] result_ff,
   output reg [`COUNT_W-1:0] count_ff,
   output reg near_short_ff
);

   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN = 2'b10;
   localparam integer NEAR_DIV = `NEAR_SHORT_DM / `COUNT_STEP_DM;
   localparam [`COUNT_W-1:0] NEAR_LIMIT = NEAR_DIV[`COUNT_W-1:0];

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [`TMO_W-1:0] tmo_ff;
   reg [`TMO_W-1:0] nxt_tmo;
   wire timed_out;

   assign timed_out = (tmo_ff >= TIMEOUT_CYCLES - 24'd1);
   assign busy_out = state_ff[1];
   assign req_out = state_ff[1];

   always @* begin
      nxt_state = state_ff;
      nxt_tmo = tmo_ff;
      done_out = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            nxt_tmo = `RST_TMO;
            if (start_in) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            nxt_tmo = tmo_ff + 24'd1;
            if (ack_in || timed_out) begin
               nxt_state = ST_IDLE;
               done_out = ce_in;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_ff <= ST_IDLE;
         tmo_ff <= `RST_TMO;
         result_ff <= `RES_NORMAL;
         count_ff <= `RST_COUNT;
         near_short_ff <= 1'b0;
      end else if (ce_in) begin
         state_ff <= nxt_state;
         tmo_ff <= nxt_tmo;
         if (state_ff[1] && ack_in) begin
            result_ff <= fe_result_in;
            count_ff <= fe_count_in;
            near_short_ff <= (fe_result_in == `RES_SHORT) && (fe_count_in < NEAR_LIMIT);
         end else if (state_ff[1] && timed_out) begin
            // A silent front end must not leave the start bit stuck high.
            result_ff <= `RES_FAIL;
            count_ff <= `RST_COUNT;
            near_short_ff <= 1'b0;
         end
      end
   end

endmodule

// ### diag_front_end_model.sv
// Behavioural model of the cable front end that answers diagnostic requests.
// Assumes requests and answers share clk_in; delay 8'hff answers only on the 256th request cycle.
`timescale 1ns/1ps
module diag_front_end_model (
   input wire clk_in,
   input wire reset_n_in,
   input wire req_in,
   input wire [7:0] delay_in,
   input wire [1:0] res_in,
   input wire [8:0] cnt_in,
   output wire ack_out,
   output wire [1:0] result_out,
   output wire [8:0] count_out
);
   reg [7:0] wait_ff;
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) wait_ff <= 8'h00;
      else if (!req_in) wait_ff <= 8'h00;
      else wait_ff <= wait_ff + 8'h01;
   end
   assign ack_out = req_in && wait_ff == delay_in;
   // Outside the answer the lines wander so a stale capture shows up.
   assign result_out = ack_out ? res_in : wait_ff[1:0];
   assign count_out = ack_out ? cnt_in : {wait_ff, wait_ff[0]} ^ 9'h1aa;
endmodule

// ### phy_cable_diag_control_status_asserts.sv
// Concurrent checks on the ports of the PHY special control/status slice.
// Assumes ce_in stays high while checks are meant to hold.
`timescale 1ns/1ps
`include "phy_diag_regs.vh"
module phy_cable_diag_control_status_asserts (
   input wire clk_in,
   input wire reset_n_in,
   input wire ce_in,
   input wire [`ADDR_W-1:0] addr_in,
   input wire [`DATA_W-1:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   input wire [`DATA_W-1:0] rdata_out,
   input wire line_link_in,
   input wire link_status_out,
   input wire diag_req_out,
   input wire diag_ack_in,
   input wire [`SYM_W-1:0] port1_receive_pair_sym_in,
   input wire [`SYM_W-1:0] port1_mac_tx_sym_in,
   input wire [`SYM_W-1:0] port1_transmit_pair_sym_out,
   input wire [`SYM_W-1:0] port2_receive_pair_sym_in,
   input wire [`SYM_W-1:0] port2_mac_tx_sym_in,
   input wire [`SYM_W-1:0] port2_transmit_pair_sym_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   wire rd_2a = ce_in && rd_in && addr_in == `OFS_P2_SPECIAL;
   wire wr_2a = ce_in && wr_in && addr_in == `OFS_P2_SPECIAL;
   reg p1_lb_seen;
   reg p2_lb_seen;
   // Loop selects as the bus has set them, so a swapped mux is caught.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         p1_lb_seen <= 1'b0;
         p2_lb_seen <= 1'b0;
      end else begin
         if (wr_2a) p2_lb_seen <= wdata_in[`BIT_REMOTE_LB];
         if (ce_in && wr_in && addr_in == `OFS_P1_SPECIAL) p1_lb_seen <= wdata_in[`BIT_REMOTE_LB];
      end
   end
   chk_start_raises_req: assert property (
      wr_2a && wdata_in[`BIT_DIAG_START] && !diag_req_out |=> diag_req_out) else $error("start did not raise req");
   chk_ack_ends_req: assert property (
      diag_req_out && diag_ack_in |=> !diag_req_out) else $error("req stayed after ack");
   chk_busy_bit_read: assert property (
      rd_2a |=> rdata_out[`BIT_DIAG_START] == $past(diag_req_out)) else $error("busy bit wrong");
   chk_rsvd_reads_zero: assert property (
      rd_2a |=> !rdata_out[`BIT_RSVD]) else $error("reserved bit set");
   chk_port3_unmapped: assert property (
      ce_in && rd_in && (addr_in == `OFS_P3_SPECIAL || addr_in == `OFS_P3_DIST) |=> rdata_out == 8'h00)
      else $error("port 3 offset answered");
   chk_link_follows_line: assert property (
      (ce_in && line_link_in) [*4] |-> link_status_out) else $error("link not passed");
   chk_override_forces: assert property (
      wr_2a && wdata_in[`BIT_LINK_OVR] |-> ##2 link_status_out) else $error("override ignored");
   chk_p2_loop_select: assert property (
      ce_in |=> port2_transmit_pair_sym_out == $past(p2_lb_seen ? port2_receive_pair_sym_in : port2_mac_tx_sym_in))
      else $error("port 2 tx source");
   chk_p1_loop_select: assert property (
      ce_in |=> port1_transmit_pair_sym_out == $past(p1_lb_seen ? port1_receive_pair_sym_in : port1_mac_tx_sym_in))
      else $error("port 1 tx source");
   cover property (diag_req_out && diag_ack_in);
   cover property (diag_req_out && !diag_ack_in ##1 !diag_req_out);
   cover property (rd_2a ##1 rdata_out[`BIT_NEAR_SHORT]);
endmodule
bind phy_cable_diag_control_status phy_cable_diag_control_status_asserts chk (.clk_in(clk_in),
   .reset_n_in(reset_n_in), .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
   .rd_in(rd_in), .rdata_out(rdata_out), .line_link_in(line_link_in), .link_status_out(link_status_out),
   .diag_req_out(diag_req_out), .diag_ack_in(diag_ack_in), .port1_receive_pair_sym_in(port1_receive_pair_sym_in),
   .port1_mac_tx_sym_in(port1_mac_tx_sym_in), .port1_transmit_pair_sym_out(port1_transmit_pair_sym_out),
   .port2_receive_pair_sym_in(port2_receive_pair_sym_in), .port2_mac_tx_sym_in(port2_mac_tx_sym_in),
   .port2_transmit_pair_sym_out(port2_transmit_pair_sym_out));

// ### phy_cable_diag_control_status_tb_top.sv
// Self-checking bench for the PHY special control/status slice.
// Assumes the front end model above; read results checked from a queue.
`timescale 1ns/1ps
`include "phy_diag_regs.vh"
module phy_cable_diag_control_status_tb_top;
   reg clk_in = 0, reset_n_in = 0, ce_in = 1, wr_in = 0, rd_in = 0, line_link_in = 0, rd_d = 0;
   reg [7:0] addr_in = 8'h00, wdata_in = 8'h00, fe_delay = 8'h00, ec_lo;
   reg [4:0] p1_rx = 0, p1_mac = 0, p2_rx = 0, p2_mac = 0;
   reg [1:0] fe_res = 0, er;
   reg [8:0] fe_cnt = 0, ec;
   reg [15:0] e;
   reg [31:0] rnd;
   reg near;
   reg [15:0] exp_q[$];
   wire [4:0] p1_tx, p2_tx;
   wire [7:0] rdata_out;
   wire irq_out, link_status_out, diag_req_out, diag_ack_in;
   wire [1:0] diag_result_in;
   wire [8:0] diag_count_in;
   integer fail_count = 0, comparisons = 0, cycles = 0, i, n, k;
   phy_cable_diag_control_status #(.DIAG_TIMEOUT_CYCLES(24'd20)) uut (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .irq_out(irq_out), .line_link_in(line_link_in), .link_status_out(link_status_out),
      .diag_req_out(diag_req_out), .diag_ack_in(diag_ack_in), .diag_result_in(diag_result_in),
      .diag_count_in(diag_count_in), .port1_receive_pair_sym_in(p1_rx), .port1_mac_tx_sym_in(p1_mac),
      .port1_transmit_pair_sym_out(p1_tx), .port2_receive_pair_sym_in(p2_rx), .port2_mac_tx_sym_in(p2_mac),
      .port2_transmit_pair_sym_out(p2_tx));
   diag_front_end_model fe (.clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(diag_req_out),
      .delay_in(fe_delay), .res_in(fe_res), .cnt_in(fe_cnt), .ack_out(diag_ack_in),
      .result_out(diag_result_in), .count_out(diag_count_in));
   initial forever #20 clk_in = ~clk_in;
   task automatic check(input [7:0] seen, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task test_done;
      begin
         $display("mismatches %0d comparisons %0d", fail_count, comparisons);
         if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk_in);
         addr_in <= a;
         wdata_in <= d;
         wr_in <= 1;
         @(posedge clk_in);
         wr_in <= 0;
      end
   endtask
   task rd(input [7:0] a, input [7:0] v, input [7:0] m);
      begin
         exp_q.push_back({m, v & m});
         @(posedge clk_in);
         addr_in <= a;
         rd_in <= 1;
         @(posedge clk_in);
         rd_in <= 0;
      end
   endtask
   // ----------------------------------------------------------------------
   // Read result watcher and hang guard
   // ----------------------------------------------------------------------
   always @(posedge clk_in) rd_d <= rd_in;
   always @(negedge clk_in) begin
      if (rd_d) begin
         e = exp_q.pop_front();
         check(rdata_out & e[15:8], e[7:0]);
      end
   end
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         test_done;
      end
   end
   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      rnd = $urandom(78061);
      repeat (8) @(posedge clk_in);
      reset_n_in <= 1;
      rd(`OFS_P2_SPECIAL, 8'h00, 8'hff);
      rd(`OFS_DIST_LOW, 8'h00, 8'hff);
      rd(`OFS_INT_STATUS, 8'h00, 8'hff);
      wr(`OFS_INT_MASK, 8'h01);
      // Cases: normal, open, short at 24 and 25 counts, failed, no answer.
      for (i = 0; i < 6; i = i + 1) begin
         er = (i == 3) ? 2'h2 : (i > 3) ? 2'h3 : i[1:0];
         rnd = $urandom;
         ec = (i == 2) ? 9'd24 : (i == 3) ? 9'd25 : (i == 5) ? 9'h000 : rnd[8:0];
         fe_res <= er;
         fe_cnt <= ec;
         fe_delay <= (i == 5) ? 8'hff : 8'd2 + {4'h0, rnd[12:9]} % 8'd9;
         near = er == `RES_SHORT && ec < 9'd25;
         wr(`OFS_P2_SPECIAL, 8'h10);
         rd(`OFS_P2_SPECIAL, 8'h10, 8'h10);
         for (n = 0; n < 40 && diag_req_out !== 1'b0; n = n + 1) @(negedge clk_in);
         check({7'h0, diag_req_out}, 8'h00);
         rd(`OFS_P2_SPECIAL, {near, er, 4'h0, ec[8]}, 8'hf1);
         ec_lo = ec[7:0];
         rd(`OFS_DIST_LOW, ec_lo, 8'hff);
         @(negedge clk_in);
         check({7'h0, irq_out}, 8'h01);
         wr(`OFS_INT_MASK, 8'h00);
         @(negedge clk_in);
         check({7'h0, irq_out}, 8'h00);
         wr(`OFS_INT_STATUS, 8'h01);
         wr(`OFS_INT_MASK, 8'h01);
         @(negedge clk_in);
         check({7'h0, irq_out}, 8'h00);
      end
      wr(`OFS_P2_SPECIAL, 8'he5);
      rd(`OFS_P2_SPECIAL, 8'h60, 8'hff);
      wr(`OFS_DIST_LOW, 8'hff);
      rd(`OFS_DIST_LOW, 8'h00, 8'hff);
      wr(`OFS_P3_SPECIAL, 8'hff);
      rd(`OFS_P3_SPECIAL, 8'h00, 8'hff);
      rd(`OFS_P3_DIST, 8'h00, 8'hff);
      wr(`OFS_P2_SPECIAL, 8'h08);
      repeat (3) @(negedge clk_in);
      check({7'h0, link_status_out}, 8'h01);
      rd(`OFS_P2_SPECIAL, 8'h08, 8'h0e);
      wr(`OFS_P2_SPECIAL, 8'h00);
      repeat (4) @(negedge clk_in);
      check({7'h0, link_status_out}, 8'h00);
      @(posedge clk_in) line_link_in <= 1;
      repeat (5) @(negedge clk_in);
      check({7'h0, link_status_out}, 8'h01);
      rd(`OFS_INT_STATUS, 8'h02, 8'hff);
      wr(`OFS_INT_STATUS, 8'h02);
      rd(`OFS_INT_STATUS, 8'h00, 8'hff);
      rd(`OFS_INT_MASK, 8'h01, 8'hff);
      // A write while ce_in is low must be lost.
      @(posedge clk_in) ce_in <= 0;
      wr(`OFS_P2_SPECIAL, 8'h0a);
      @(posedge clk_in) ce_in <= 1;
      rd(`OFS_P2_SPECIAL, 8'h00, 8'h0e);
      wr(`OFS_P2_SPECIAL, 8'h02);
      wr(`OFS_P1_SPECIAL, 8'h02);
      rd(`OFS_P1_SPECIAL, 8'h02, 8'hff);
      rd(`OFS_P2_SPECIAL, 8'h02, 8'h0e);
      for (k = 0; k < 2; k = k + 1) begin
         for (n = 0; n < 8; n = n + 1) begin
            rnd = $urandom;
            @(posedge clk_in) {p1_rx, p1_mac, p2_rx, p2_mac} <= rnd[19:0];
            @(posedge clk_in);
            @(negedge clk_in);
            check({3'h0, p2_tx}, {3'h0, k ? p2_mac : p2_rx});
            check({3'h0, p1_tx}, {3'h0, k ? p1_mac : p1_rx});
         end
         wr(`OFS_P2_SPECIAL, 8'h00);
         wr(`OFS_P1_SPECIAL, 8'h00);
      end
      repeat (4) @(posedge clk_in);
      test_done;
   end
endmodule
